// >>> ptmux_defs.vh
/*
 * shared constants of the port two / port three function multiplexer:
 * pin indices, pad counts and reset values of the port controls.
 * assumes nothing; definitions only.
 */
`ifndef PTMUX_DEFS_VH
`define PTMUX_DEFS_VH

// ----------------------------------------------------------------
// port widths
// ----------------------------------------------------------------
`define PTMUX_PORT_W 8
`define PTMUX_P2_PADS 6

// ----------------------------------------------------------------
// pin indices
// ----------------------------------------------------------------
`define PTMUX_P2_ACLK 0
`define PTMUX_P2_TCLK 1
`define PTMUX_P2_CMPO 2
`define PTMUX_P2_OUT1 3
`define PTMUX_P2_OUT2 4
`define PTMUX_P2_OSCILLATOR_RESISTOR_FUNCTION 5
`define PTMUX_P3_STE 0
`define PTMUX_P3_SIMO 1
`define PTMUX_P3_SOMI 2
`define PTMUX_P3_CLK 3
`define PTMUX_P3_TXD 4
`define PTMUX_P3_RXD 5
`define PTMUX_P3_NC_LO 6
`define PTMUX_P3_NC_HI 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTMUX_RST_BYTE 8'h00

`endif

// >>> ptmux_pin.v
/*
 * one pad cell: selects port or peripheral output and direction,
 * and resynchronises the pad level through two flip-flops.
 * assumes the pad arrives asynchronously to clk.
 */
`timescale 1ns/1ps
`include "ptmux_defs.vh"

module ptmux_pin (
	// clock and reset
	input wire clk,
	input wire rst,
	// controls
	input wire function_select_bit,
	input wire direction_bit,
	input wire output_value_bit,
	input wire force_dir_en,
	input wire force_dir_val,
	input wire periph_out,
	// pad
	input wire pad_in,
	output reg pad_out,
	output reg pad_oe,
	output reg input_value_bit
);

reg pad_meta;
reg next_out;
reg next_oe;

// ----------------------------------------------------------------
// output and direction select
// ----------------------------------------------------------------
always @* begin
	next_out = function_select_bit ? periph_out : output_value_bit;
	next_oe = direction_bit;
	if (function_select_bit && force_dir_en) begin
		next_oe = force_dir_val;
	end
end

// registered pad drive and two-stage input sync
always @(posedge clk or posedge rst) begin
	if (rst) begin
		pad_out <= 1'b0;
		pad_oe <= 1'b0;
		pad_meta <= 1'b0;
		input_value_bit <= 1'b0;
	end else begin
		pad_out <= next_out;
		pad_oe <= next_oe;
		pad_meta <= pad_in;
		input_value_bit <= pad_meta;
	end
end

endmodule

// >>> ptmux_top.v
/*
 * function multiplexer for ports two and three: port i/o or peripheral
 * signals per pin, forced serial directions, pin interrupt flags with
 * software-only flags on the unbonded port two bits.
 * assumes peripherals and the cpu port registers share clk.
 */
// Overview of operation
// R1: p2.0 selected drives auxiliary clock; own direction bit keeps direction.
// R2: p2.1 pad input feeds timer external clock input.
// R3: p2.3 and p2.4 selected drive timer compare outputs one and two.
// R4: p2.5 peripheral output is tied low, no peripheral input.
// R5: p2.6 and p2.7 have no pads but keep usable interrupt flags.
// R6: unbonded flags change only by software writes, never by pins.
// R7: p3.0 selected is forced input, feeding serial slave transmit enable.
// R8: p3.4 selected is forced output, driving serial transmit data.
// R9: p3.5 selected is forced input, feeding serial receive data.
// R10: asynchronous mode with p3.3 selected keeps shift clock pin input.
// R11: synchronous slave takes shift clock from outside on p3.3.
// R12: synchronous master drives shift clock out on p3.3.
// R13: p3.6 and p3.7 selected are forced input, output tied low.
// R14: unselected pins act as plain port i/o.
`timescale 1ns/1ps
`include "ptmux_defs.vh"

module ptmux_top #(
	parameter W = `PTMUX_PORT_W
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// port two controls
	input wire [W-1:0] p2_function_select_bit,
	input wire [W-1:0] p2_direction_bit,
	input wire [W-1:0] p2_output_value_bit,
	input wire [W-1:0] p2_pin_interrupt_enable_bit,
	input wire [W-1:0] p2_interrupt_edge_select_bit,
	input wire [W-1:0] p2_flag_write_en,
	input wire [W-1:0] p2_flag_write_data,
	// port three controls
	input wire [W-1:0] p3_function_select_bit,
	input wire [W-1:0] p3_direction_bit,
	input wire [W-1:0] p3_output_value_bit,
	// peripheral outputs toward the pads
	input wire aux_clock,
	input wire comparator_output,
	input wire timer_compare_out_one,
	input wire timer_compare_out_two,
	input wire serial_transmit_data,
	input wire serial_simo_out,
	input wire serial_somi_out,
	input wire serial_shift_clock_out,
	input wire serial_sync_mode,
	input wire serial_master_mode,
	// pads
	input wire [W-1:0] p2_pad_in,
	output wire [W-1:0] p2_pad_out,
	output wire [W-1:0] p2_pad_oe,
	input wire [W-1:0] p3_pad_in,
	output wire [W-1:0] p3_pad_out,
	output wire [W-1:0] p3_pad_oe,
	// port readback
	output wire [W-1:0] p2_input_value_bit,
	output wire [W-1:0] p3_input_value_bit,
	output reg [W-1:0] p2_pin_interrupt_flag_bit,
	output reg p2_interrupt,
	// peripheral inputs from the pads
	output reg timer_external_clock_in,
	output reg timer_capture_input_zero_b,
	output reg serial_slave_transmit_enable,
	output reg serial_receive_data,
	output reg serial_simo_in,
	output reg serial_somi_in,
	output reg serial_shift_clock_in
);

reg [W-1:0] p2_periph;
reg [W-1:0] p3_periph;
reg [W-1:0] p3_force_en;
reg [W-1:0] p3_force_val;
reg [W-1:0] p2_prev;
reg [W-1:0] next_flag;
wire [W-1:0] p2_in_sync;
wire [W-1:0] p2_pad_in_masked;
wire [W-1:0] p2_event;
genvar i;

// ----------------------------------------------------------------
// peripheral output and forced direction per pin
// ----------------------------------------------------------------
always @* begin
	p2_periph = {W{1'b0}}; // bits 5..7 stay low [R4] [R5]
	p2_periph[`PTMUX_P2_ACLK] = aux_clock; // [R1]
	p2_periph[`PTMUX_P2_CMPO] = comparator_output;
	p2_periph[`PTMUX_P2_OUT1] = timer_compare_out_one; // [R3]
	p2_periph[`PTMUX_P2_OUT2] = timer_compare_out_two; // [R3]
	p3_periph = {W{1'b0}}; // bits 6,7 output low [R13]
	p3_periph[`PTMUX_P3_TXD] = serial_transmit_data; // [R8]
	p3_periph[`PTMUX_P3_SIMO] = serial_simo_out;
	p3_periph[`PTMUX_P3_SOMI] = serial_somi_out;
	p3_periph[`PTMUX_P3_CLK] = serial_shift_clock_out; // [R12]
	// forced directions: 0,5,6,7 input, 4 output, 3 by serial mode
	p3_force_en = {W{1'b0}};
	p3_force_en[`PTMUX_P3_STE] = 1'b1; // [R7]
	p3_force_en[`PTMUX_P3_TXD] = 1'b1; // [R8]
	p3_force_en[`PTMUX_P3_RXD] = 1'b1; // [R9]
	p3_force_en[`PTMUX_P3_NC_LO] = 1'b1; // [R13]
	p3_force_en[`PTMUX_P3_NC_HI] = 1'b1; // [R13]
	p3_force_en[`PTMUX_P3_CLK] = 1'b1; // [R10]
	p3_force_val = {W{1'b0}};
	p3_force_val[`PTMUX_P3_TXD] = 1'b1; // [R8]
	// clock pin: input in uart and spi slave, output in spi master
	p3_force_val[`PTMUX_P3_CLK] =
		serial_sync_mode & serial_master_mode; // [R10] [R11] [R12]
	// spi data pins follow master or slave role
	// in uart mode both data pins stay under their own direction bits
	p3_force_en[`PTMUX_P3_SIMO] = serial_sync_mode;
	p3_force_val[`PTMUX_P3_SIMO] = serial_master_mode;
	p3_force_en[`PTMUX_P3_SOMI] = serial_sync_mode;
	p3_force_val[`PTMUX_P3_SOMI] = ~serial_master_mode;
end

// ----------------------------------------------------------------
// pad cells; port two never forces direction [R1] [R14]
// ----------------------------------------------------------------
generate
	for (i = 0; i < W; i = i + 1) begin : g_pin
		ptmux_pin u_p2 (
			.clk(clk),
			.rst(rst),
			.function_select_bit(p2_function_select_bit[i]),
			.direction_bit(p2_direction_bit[i]),
			.output_value_bit(p2_output_value_bit[i]),
			.force_dir_en(1'b0),
			.force_dir_val(1'b0),
			.periph_out(p2_periph[i]),
			.pad_in(p2_pad_in_masked[i]),
			.pad_out(p2_pad_out[i]),
			.pad_oe(p2_pad_oe[i]),
			.input_value_bit(p2_in_sync[i])
		);
		ptmux_pin u_p3 (
			.clk(clk),
			.rst(rst),
			.function_select_bit(p3_function_select_bit[i]),
			.direction_bit(p3_direction_bit[i]),
			.output_value_bit(p3_output_value_bit[i]),
			.force_dir_en(p3_force_en[i]),
			.force_dir_val(p3_force_val[i]),
			.periph_out(p3_periph[i]),
			.pad_in(p3_pad_in[i]),
			.pad_out(p3_pad_out[i]),
			.pad_oe(p3_pad_oe[i]),
			.input_value_bit(p3_input_value_bit[i]) // [R14]
		);
	end
endgenerate

// unbonded bits have no pad: their input reads zero [R5]
// tying them low also keeps a floating pad out of the edge detector
assign p2_pad_in_masked = {{(W-`PTMUX_P2_PADS){1'b0}},
	p2_pad_in[`PTMUX_P2_PADS-1:0]};
assign p2_input_value_bit = p2_in_sync;

// ----------------------------------------------------------------
// pin interrupt flags
// ----------------------------------------------------------------
// a pad edge reaches its flag three edges later: two sync flops,
// then the flag register, fed by the compare against p2_prev
// edge on synced input, rising or falling by edge select; pads only
assign p2_event = {{(W-`PTMUX_P2_PADS){1'b0}}, {`PTMUX_P2_PADS{1'b1}}}
	& ((~p2_interrupt_edge_select_bit & ~p2_prev & p2_in_sync)
	| (p2_interrupt_edge_select_bit & p2_prev & ~p2_in_sync)); // [R6]

// software write, then pin event wins over a clear
// so an edge arriving with a software clear is never lost
always @* begin
	next_flag = (p2_pin_interrupt_flag_bit & ~p2_flag_write_en)
		| (p2_flag_write_data & p2_flag_write_en); // [R5] [R6]
	next_flag = next_flag | p2_event;
end

// flag, edge history and interrupt registers
always @(posedge clk or posedge rst) begin
	if (rst) begin
		p2_prev <= `PTMUX_RST_BYTE;
		p2_pin_interrupt_flag_bit <= `PTMUX_RST_BYTE;
		p2_interrupt <= 1'b0;
	end else begin
		p2_prev <= p2_in_sync;
		p2_pin_interrupt_flag_bit <= next_flag;
		p2_interrupt <= |(next_flag & p2_pin_interrupt_enable_bit);
	end
end

// ----------------------------------------------------------------
// peripheral inputs from the pads
// ----------------------------------------------------------------
// routed whatever the select bits say; each peripheral decides
// when it listens, so a deselected pin only costs a toggling input
always @(posedge clk or posedge rst) begin
	if (rst) begin
		timer_external_clock_in <= 1'b0;
		timer_capture_input_zero_b <= 1'b0;
		serial_slave_transmit_enable <= 1'b0;
		serial_receive_data <= 1'b0;
		serial_simo_in <= 1'b0;
		serial_somi_in <= 1'b0;
		serial_shift_clock_in <= 1'b0;
	end else begin
		timer_external_clock_in <= p2_in_sync[`PTMUX_P2_TCLK]; // [R2]
		timer_capture_input_zero_b <= p2_in_sync[`PTMUX_P2_CMPO];
		serial_slave_transmit_enable <=
			p3_input_value_bit[`PTMUX_P3_STE]; // [R7]
		serial_receive_data <= p3_input_value_bit[`PTMUX_P3_RXD]; // [R9]
		serial_simo_in <= p3_input_value_bit[`PTMUX_P3_SIMO];
		serial_somi_in <= p3_input_value_bit[`PTMUX_P3_SOMI];
		serial_shift_clock_in <=
			p3_input_value_bit[`PTMUX_P3_CLK]; // [R11]
	end
end

endmodule

// >>> ptmux_assertions.sv
/* checker for the port two / three mux: pad drive, forced directions
   and software flags. assumes a bind onto ptmux_top, one clock. */
`timescale 1ns/1ps
module ptmux_assertions #(parameter W = 8) (
	// clock and reset
	input wire clk,
	input wire rst,
	// controls and peripheral outputs
	input wire [W-1:0] p2_function_select_bit,
	input wire [W-1:0] p2_direction_bit,
	input wire [W-1:0] p2_output_value_bit,
	input wire [W-1:0] p2_flag_write_en,
	input wire [W-1:0] p3_function_select_bit,
	input wire aux_clock,
	input wire timer_compare_out_one,
	input wire timer_compare_out_two,
	input wire serial_transmit_data,
	input wire serial_shift_clock_out,
	input wire serial_sync_mode,
	input wire serial_master_mode,
	// observed outputs
	input wire [W-1:0] p2_pad_out,
	input wire [W-1:0] p2_pad_oe,
	input wire [W-1:0] p3_pad_out,
	input wire [W-1:0] p3_pad_oe,
	input wire [W-1:0] p2_pin_interrupt_flag_bit
);
	reg [1:0] up;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// waits two edges after reset so $past sees live controls
	always @(posedge clk or posedge rst) begin
		if (rst)
			up <= 2'b00;
		else
			up <= {up[0], 1'b1};
	end
	aclk_pin_a: assert property (up[1]
		&& $past(p2_function_select_bit[0])
		|-> p2_pad_out[0] == $past(aux_clock)
		&& p2_pad_oe[0] == $past(p2_direction_bit[0])) else $error("aux pin");
	cmp_pins_a: assert property (up[1]
		&& &$past(p2_function_select_bit[4:3])
		|-> p2_pad_out[4:3] == $past({timer_compare_out_two,
		timer_compare_out_one})) else $error("compare pins");
	port_io_a: assert property (up[1] |-> (((p2_pad_out
		^ $past(p2_output_value_bit)) | (p2_pad_oe ^ $past(p2_direction_bit)))
		& ~$past(p2_function_select_bit) & 8'h3f) == 8'h00) else $error("gpio");
	sw_flags_a: assert property (up[1]
		&& $past(p2_flag_write_en[7:6]) == 2'b00
		|-> $stable(p2_pin_interrupt_flag_bit[7:6])) else $error("sw flag");
	txd_pin_a: assert property (up[1] && $past(p3_function_select_bit[4])
		|-> p3_pad_oe[4] && p3_pad_out[4] == $past(serial_transmit_data))
		else $error("txd pin");
	forced_in_a: assert property (up[1] |->
		((p3_pad_oe | p3_pad_out) & $past(p3_function_select_bit) & 8'he1)
		== 8'h00) else $error("forced input");
	clk_in_a: assert property (up[1]
		&& $past(p3_function_select_bit[3]
		&& !(serial_sync_mode && serial_master_mode)) |-> !p3_pad_oe[3])
		else $error("clock input");
	clk_out_a: assert property (up[1] && $past(p3_function_select_bit[3]
		&& serial_sync_mode && serial_master_mode) |-> p3_pad_oe[3]
		&& p3_pad_out[3] == $past(serial_shift_clock_out)) else $error("clk out");
	cover property (up[1] && p3_pad_oe[3]);
	cover property (up[1] && p3_pad_oe[4]);
	cover property (up[1] && p2_pin_interrupt_flag_bit[7]);
endmodule

// >>> ptmux_periph.sv
/* peripheral-side model: aux clock, comparator, timer and serial outputs.
   assumes the same clk and rst as the mux. */
`timescale 1ns/1ps
module ptmux_periph (
	// clock and reset
	input wire clk,
	input wire rst,
	// peripheral outputs
	output reg aux_clock,
	output reg comparator_output,
	output reg timer_compare_out_one,
	output reg timer_compare_out_two,
	output reg serial_transmit_data,
	output reg serial_simo_out,
	output reg serial_somi_out,
	output reg serial_shift_clock_out
);
	reg [3:0] cnt;
	// free counter so every output keeps moving
	always @(posedge clk or posedge rst) begin
		if (rst)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
	end
	// each output a distinct function of cnt, so a swapped pin is seen
	always @* begin
		aux_clock = cnt[0];
		comparator_output = cnt[1];
		timer_compare_out_one = cnt[2];
		timer_compare_out_two = cnt[1] ^ cnt[3];
		serial_transmit_data = cnt[3];
		serial_simo_out = cnt[2] ^ cnt[0];
		serial_somi_out = ~cnt[2];
		serial_shift_clock_out = ~cnt[0]; // master shift clock
	end
endmodule

// >>> testbench.sv
/* testbench for ptmux_top: port i/o, peripheral routing, forced serial
   directions and software flags. assumes ptmux_periph drives outputs. */
`timescale 1ns/1ps
module testbench;
	logic clk, rst, serial_sync_mode, serial_master_mode, p2_interrupt;
	logic aux_clock, comparator_output, timer_compare_out_one;
	logic timer_compare_out_two, serial_transmit_data, serial_simo_out;
	logic serial_somi_out, serial_shift_clock_out, timer_external_clock_in;
	logic timer_capture_input_zero_b, serial_slave_transmit_enable;
	logic serial_receive_data, serial_simo_in, serial_somi_in;
	logic serial_shift_clock_in;
	logic [7:0] p2_function_select_bit, p2_direction_bit, p2_output_value_bit;
	logic [7:0] p2_pin_interrupt_enable_bit, p2_interrupt_edge_select_bit;
	logic [7:0] p2_flag_write_en, p2_flag_write_data, p2_pad_in, p3_pad_in;
	logic [7:0] p3_function_select_bit, p3_direction_bit, p3_output_value_bit;
	logic [7:0] p2_pad_out, p2_pad_oe, p3_pad_out, p3_pad_oe;
	logic [7:0] p2_input_value_bit, p3_input_value_bit;
	logic [7:0] p2_pin_interrupt_flag_bit;
	int miscompares = 0, check_count = 0, m;
	ptmux_top dut (.*);
	ptmux_periph far (.*);
	// steps n edges, then a fixed small delay
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		conclude;
	end
	// --------
	// scenarios
	// --------
	initial begin
		rst = 1'b1;
		{serial_sync_mode, serial_master_mode, p2_function_select_bit,
			p2_direction_bit, p2_output_value_bit, p2_pin_interrupt_enable_bit,
			p2_interrupt_edge_select_bit, p2_flag_write_en, p2_flag_write_data,
			p2_pad_in, p3_pad_in, p3_function_select_bit, p3_direction_bit,
			p3_output_value_bit} = '0;
		step(8);
		rst = 1'b0;
		step(1);
		p2_direction_bit = 8'h5a;
		p2_output_value_bit = 8'h3c;
		p3_direction_bit = 8'ha5;
		p3_output_value_bit = 8'h0f;
		p2_pad_in = 8'h06;
		p3_pad_in = 8'h25;
		step(4);
		chk("p2 oe", p2_pad_oe & 8'h3f, 8'h1a);
		chk("p2 out", p2_pad_out & 8'h3f, 8'h3c);
		chk("p3 oe", p3_pad_oe, 8'ha5);
		chk("p3 out", p3_pad_out, 8'h0f);
		chk("p3 in", p3_input_value_bit, 8'h25);
		chk("p2 in", p2_input_value_bit, 8'h06);
		chk("pad flags", p2_pin_interrupt_flag_bit, 8'h06);
		chk("timer_capture_input_zero_b", {7'h00, timer_capture_input_zero_b}, 8'h01);
		chk("data in", {6'h00, serial_somi_in, serial_simo_in}, 8'h02);
		chk("tclk", {7'h00, timer_external_clock_in}, 8'h01);
		chk("ste", {7'h00, serial_slave_transmit_enable}, 8'h01);
		chk("rxd", {7'h00, serial_receive_data}, 8'h01);
		// clear the pad flags, then bit 2 falls with falling edges chosen
		p2_pad_in = 8'hc0;
		p2_pin_interrupt_enable_bit = 8'hc0;
		p2_interrupt_edge_select_bit = 8'h04;
		p2_flag_write_en = 8'h06;
		step(1);
		p2_flag_write_en = 8'h00;
		step(5);
		chk("tclk low", {7'h00, timer_external_clock_in}, 8'h00);
		chk("pin flags", p2_pin_interrupt_flag_bit & 8'hc0, 8'h00);
		chk("fall flag", p2_pin_interrupt_flag_bit & 8'h3f, 8'h04);
		p2_flag_write_en = 8'hc0;
		p2_flag_write_data = 8'hc0;
		step(1);
		p2_flag_write_en = 8'h40;
		p2_flag_write_data = 8'h00;
		step(1);
		p2_flag_write_en = 8'h00;
		chk("sw flags", p2_pin_interrupt_flag_bit & 8'hc0, 8'h80);
		chk("irq", {7'h00, p2_interrupt}, 8'h01);
		p2_pin_interrupt_enable_bit = 8'h40;
		step(2);
		chk("irq masked", {7'h00, p2_interrupt}, 8'h00);
		p2_function_select_bit = 8'h3f;
		p2_direction_bit = 8'h01;
		step(2);
		chk("aclk oe", p2_pad_oe & 8'h01, 8'h01);
		chk("p2.5 low", p2_pad_out & 8'h20, 8'h00);
		p3_function_select_bit = 8'hff;
		p3_direction_bit = 8'he1;
		p3_pad_in = 8'h08; // shift clock from the far side
		for (m = 0; m < 3; m++) begin
			serial_sync_mode = (m > 0);
			serial_master_mode = (m == 2);
			step(4);
			chk("p3 forced", p3_pad_oe,
				m == 2 ? 8'h1a : (m == 1 ? 8'h14 : 8'h10));
			chk("p3 low", p3_pad_out & 8'he1, 8'h00);
			chk("clk in", {7'h00, serial_shift_clock_in}, 8'h01);
		end
		conclude;
	end
endmodule
bind ptmux_top ptmux_assertions #(.W(W)) chk_mux (.*);
